// ---- core/acr_pkg.sv ----
// package: register map, fields and types of the converter control block
package acr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CFG_TWO = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;
    localparam logic [7:0] OFS_IRQ_CFG = 8'h18;
    localparam logic [7:0] OFS_PIN_LOW = 8'h1c;
    localparam logic [7:0] OFS_SCAN = 8'h00;
    localparam logic [7:0] OFS_CHAN = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_SRC_BIT = 8;
    localparam int CFG_REF_BIT = 7;
    localparam int CFG_TAP_LO = 5;
    localparam int CFG_OFS_LO = 3;
    localparam int CFG_BUF_BIAS_BIT = 2;
    localparam int CFG_CMP_BIAS_BIT = 1;
    localparam int CFG_FILT_BIT = 0;
    localparam int IRQ_CLR_BIT = 2;
    localparam int IRQ_FLAG_BIT = 1;
    localparam int IRQ_EN_BIT = 0;
    localparam int PIN_RSVD_BIT = 16;
    localparam int RES_W = 12;
    localparam int CHAN_W = 6;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [8:0] CFG_TWO_RST = 9'h010;
    localparam logic [31:0] PIN_LOW_RST = 32'h00000000;
    localparam logic [31:0] PIN_LOW_MASK = 32'hfffeffff;
    localparam logic [5:0] CHAN_VREF = 6'h3c;
    localparam logic [31:0] MISS_DATA = 32'h00000000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic src_vref;
        logic ref_4v;
        logic [1:0] tap_sel;
        logic [1:0] offset_mode;
        logic buf_bias_low;
        logic cmp_bias_low;
        logic filter_on;
    } acr_cfg_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } acr_bus_type;

    typedef enum logic [1:0] {
        SCAN_IDLE,
        SCAN_BUSY
    } acr_scan_type;

endpackage : acr_pkg

// ---- core/acr_scan_ctl.sv ----
// scan sequencer: start on scan-go rising, capture result at scan end
`timescale 1ns/1ns
`default_nettype none
module acr_scan_ctl (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic go_rise_in,
    input wire logic conv_done_in,
    input wire logic [acr_pkg::RES_W-1:0] conv_data_in,
    output logic start_out,
    output logic busy_out,
    output logic done_out,
    output logic [acr_pkg::RES_W-1:0] result_out
);

    acr_pkg::acr_scan_type state_r, state_nxt;
    logic start_r, start_nxt;
    logic done_r, done_nxt;
    logic [acr_pkg::RES_W-1:0] result_r, result_nxt;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        start_nxt = 1'b0;
        done_nxt = 1'b0;
        result_nxt = result_r;
        case (state_r)
            acr_pkg::SCAN_IDLE:
            begin
                if (go_rise_in)
                begin
                    start_nxt = 1'b1;
                    state_nxt = acr_pkg::SCAN_BUSY;
                end
            end
            acr_pkg::SCAN_BUSY:
            begin
                if (conv_done_in)
                begin
                    result_nxt = conv_data_in;
                    done_nxt = 1'b1;
                    state_nxt = acr_pkg::SCAN_IDLE;
                end
            end
            default:
            begin
                state_nxt = acr_pkg::SCAN_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            state_r <= acr_pkg::SCAN_IDLE;
            start_r <= 1'b0;
            done_r <= 1'b0;
            result_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            start_r <= start_nxt;
            done_r <= done_nxt;
            result_r <= result_nxt;
        end
    end

    assign start_out = start_r;
    assign busy_out = (state_r == acr_pkg::SCAN_BUSY);
    assign done_out = done_r;
    assign result_out = result_r;

endmodule : acr_scan_ctl
`default_nettype wire

// ---- core/acr_regs.sv ----
// top: register file, interrupt and pin selects of the converter control
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - bit 8 picks supply rail (0) or reference generator (1) as output
// - bit 7 picks 2V reference when clear, 4V when set
// - bits 6:5 pick channel sixty voltage: 1.362, 2.253, 3.111, 4.082V
// - offset-cancel bits 4:3 reset to 10; 0x before, 1x during sampling
// - bit 2 buffer bias, bit 1 comparator bias; 0 is 5uA, 1 is 4uA
// - bit 0 inserts RC input filter when set, bypasses when clear
// - result register shows latest 12-bit value, upper bits read zero
// - writing 1 to clear bit 2 clears status flag; 0 does nothing
// - status flag bit 1 is read-only, 1 while interrupt pending
// - enable bit 0 passes completion interrupt; clear means polling only while mask bit 0 at 0x24 is clear
// - pin-select bit n switches pin n to analog input function
// - clear bit leaves pin digital; bit 16 reserved, reads zero
// - scan-go rising starts one scan; hardware clears it at scan end
// - channel code 111100 routes reference generator to converter
module acr_regs (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic conv_done_in,
    input wire logic [acr_pkg::RES_W-1:0] conv_data_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out,
    output logic conv_start_out,
    output logic [acr_pkg::CHAN_W-1:0] conv_chan_out,
    output logic vref_to_conv_out,
    output acr_pkg::acr_cfg_type cfg_out,
    output logic [31:0] pin_analog_out
);

    acr_pkg::acr_bus_type bus;
    acr_pkg::acr_cfg_type cfg_r, cfg_nxt;
    logic [31:0] pin_r, pin_nxt;
    logic [acr_pkg::CHAN_W-1:0] chan_r, chan_nxt;
    logic go_r, go_nxt;
    logic int_en_r, int_en_nxt;
    logic flag_r, flag_nxt;
    logic mask_r, mask_nxt;
    logic sticky_r, sticky_nxt;
    logic irq_r, irq_nxt;
    logic vref_r, vref_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic go_rise;
    logic scan_busy;
    logic scan_done;
    logic [acr_pkg::RES_W-1:0] result;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in,
                   wr: reg_wr_in, rd: reg_rd_in};

    // ------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------
    assign go_rise = bus.wr && hit(bus.addr, acr_pkg::OFS_SCAN)
                     && bus.wdata[0] && !go_r;

    acr_scan_ctl u_scan (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .go_rise_in(go_rise),
        .conv_done_in(conv_done_in),
        .conv_data_in(conv_data_in),
        .start_out(conv_start_out),
        .busy_out(scan_busy),
        .done_out(scan_done),
        .result_out(result)
    );

    // ------------------------------------------------------------
    // register writes and hardware events
    // ------------------------------------------------------------
    always_comb
    begin
        cfg_nxt = cfg_r;
        pin_nxt = pin_r;
        chan_nxt = chan_r;
        go_nxt = go_r;
        int_en_nxt = int_en_r;
        flag_nxt = flag_r;
        mask_nxt = mask_r;
        sticky_nxt = sticky_r;
        if (bus.wr)
        begin
            if (hit(bus.addr, acr_pkg::OFS_CFG_TWO))
            begin
                cfg_nxt = bus.wdata[8:0];
            end
            if (hit(bus.addr, acr_pkg::OFS_PIN_LOW))
            begin
                pin_nxt = bus.wdata & acr_pkg::PIN_LOW_MASK;
            end
            if (hit(bus.addr, acr_pkg::OFS_CHAN))
            begin
                chan_nxt = bus.wdata[acr_pkg::CHAN_W-1:0];
            end
            if (hit(bus.addr, acr_pkg::OFS_SCAN))
            begin
                go_nxt = bus.wdata[0] | go_r;
            end
            if (hit(bus.addr, acr_pkg::OFS_IRQ_MASK))
            begin
                mask_nxt = bus.wdata[0];
            end
            if (hit(bus.addr, acr_pkg::OFS_IRQ_CFG))
            begin
                int_en_nxt = bus.wdata[acr_pkg::IRQ_EN_BIT];
                if (bus.wdata[acr_pkg::IRQ_CLR_BIT])
                begin
                    flag_nxt = 1'b0;
                end
            end
        end
        if (bus.rd && hit(bus.addr, acr_pkg::OFS_IRQ_MASK))
        begin
            sticky_nxt = 1'b0;
        end
        if (scan_done)
        begin
            go_nxt = 1'b0;
            flag_nxt = 1'b1;
            sticky_nxt = 1'b1;
        end
        if (scan_busy && !go_r)
        begin
            go_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // interrupt, routing and read data
    // ------------------------------------------------------------
    always_comb
    begin
        irq_nxt = (flag_nxt && int_en_nxt) || (sticky_nxt && mask_nxt);
        vref_nxt = (chan_nxt == acr_pkg::CHAN_VREF);
        rdata_nxt = acr_pkg::MISS_DATA;
        if (bus.rd)
        begin
            case (bus.addr)
                acr_pkg::OFS_CFG_TWO:
                    rdata_nxt = {23'h000000, cfg_r};
                acr_pkg::OFS_RESULT:
                    rdata_nxt = {20'h00000, result};
                acr_pkg::OFS_IRQ_CFG:
                    rdata_nxt = {30'h00000000, flag_r, int_en_r};
                acr_pkg::OFS_PIN_LOW:
                    rdata_nxt = pin_r;
                acr_pkg::OFS_SCAN:
                    rdata_nxt = {31'h00000000, go_r};
                acr_pkg::OFS_CHAN:
                    rdata_nxt = {26'h0000000, chan_r};
                acr_pkg::OFS_IRQ_MASK:
                    rdata_nxt = {15'h0000, sticky_r, 15'h0000, mask_r};
                default:
                    rdata_nxt = acr_pkg::MISS_DATA;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            cfg_r <= acr_pkg::CFG_TWO_RST;
            pin_r <= acr_pkg::PIN_LOW_RST;
            chan_r <= '0;
            go_r <= 1'b0;
            int_en_r <= 1'b0;
            flag_r <= 1'b0;
            mask_r <= 1'b0;
            sticky_r <= 1'b0;
            irq_r <= 1'b0;
            vref_r <= 1'b0;
            rdata_r <= '0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            pin_r <= pin_nxt;
            chan_r <= chan_nxt;
            go_r <= go_nxt;
            int_en_r <= int_en_nxt;
            flag_r <= flag_nxt;
            mask_r <= mask_nxt;
            sticky_r <= sticky_nxt;
            irq_r <= irq_nxt;
            vref_r <= vref_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign irq_out = irq_r;
    assign conv_chan_out = chan_r;
    assign vref_to_conv_out = vref_r;
    assign cfg_out = cfg_r;
    assign pin_analog_out = pin_r;

endmodule : acr_regs
`default_nettype wire

// ---- verif/acr_regs_sva.sv ----
// checker: bus, config, pin and scan relations of acr_regs
`timescale 1ns/1ns
`default_nettype none
module acr_regs_sva (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic conv_done_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic irq_out,
    input wire logic conv_start_out,
    input wire logic [acr_pkg::CHAN_W-1:0] conv_chan_out,
    input wire logic vref_to_conv_out,
    input wire acr_pkg::acr_cfg_type cfg_out,
    input wire logic [31:0] pin_analog_out
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);
    a_cfg_write: assert property (
        reg_wr_in && reg_addr_in == acr_pkg::OFS_CFG_TWO
        |=> cfg_out == $past(reg_wdata_in[8:0])) else $error("cfg not taken");
    a_cfg_hold: assert property (
        !(reg_wr_in && reg_addr_in == acr_pkg::OFS_CFG_TWO)
        |=> $stable(cfg_out)) else $error("cfg changed unasked");
    a_pin_write: assert property (
        reg_wr_in && reg_addr_in == acr_pkg::OFS_PIN_LOW
        |=> pin_analog_out == ($past(reg_wdata_in) & acr_pkg::PIN_LOW_MASK))
        else $error("pin selects not taken");
    a_pin_rsvd: assert property (
        !pin_analog_out[acr_pkg::PIN_RSVD_BIT])
        else $error("reserved pin set");
    a_result_high: assert property (
        reg_rd_in && reg_addr_in == acr_pkg::OFS_RESULT
        |=> reg_rdata_out[31:12] == 20'h00000) else $error("result high bits");
    a_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data without read");
    a_start_cause: assert property (
        conv_start_out |-> $past(reg_wr_in)
        && $past(reg_addr_in) == acr_pkg::OFS_SCAN) else $error("stray start");
    a_start_pulse: assert property (
        conv_start_out |=> !conv_start_out)
        else $error("start too long");
    a_vref_route: assert property (
        vref_to_conv_out == (conv_chan_out == acr_pkg::CHAN_VREF))
        else $error("reference route wrong");
    a_irq_cause: assert property (
        $rose(irq_out) |-> $past(conv_done_in, 2) || $past(reg_wr_in))
        else $error("irq without cause");
    c_scan: cover property (conv_start_out);
    c_irq: cover property ($rose(irq_out));
    c_vref: cover property (vref_to_conv_out);
endmodule : acr_regs_sva
bind acr_regs acr_regs_sva u_sva (.clk_sys_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .conv_done_in, .reg_rdata_out,
    .irq_out, .conv_start_out, .conv_chan_out, .vref_to_conv_out, .cfg_out,
    .pin_analog_out);
`default_nettype wire

// ---- verif/acr_regs_tb_top.sv ----
// testbench: register, scan and interrupt scenarios of acr_regs
`timescale 1ns/1ns
`default_nettype none
module acr_regs_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic done = 1'b0;
    logic [11:0] cdata = 12'h000;
    logic [31:0] rdata;
    logic irq;
    logic start;
    logic [5:0] chan;
    logic vref;
    acr_pkg::acr_cfg_type cfg;
    logic [31:0] pins;
    int error_cnt = 0;
    int checks = 0;
    acr_regs uut (.clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .conv_done_in(done), .conv_data_in(cdata), .reg_rdata_out(rdata),
        .irq_out(irq), .conv_start_out(start), .conv_chan_out(chan),
        .vref_to_conv_out(vref), .cfg_out(cfg), .pin_analog_out(pins));
    initial
    begin
        forever #20 clk = ~clk;
    end
    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        chk(32'(cfg), 32'h10);
        chk(pins, 32'h0);
        chk(32'(irq), 32'h0);
        rd_chk(acr_pkg::OFS_CFG_TWO, 32'h10);
        rd_chk(acr_pkg::OFS_RESULT, 32'h0);
        rd_chk(acr_pkg::OFS_IRQ_CFG, 32'h0);
        rd_chk(acr_pkg::OFS_PIN_LOW, 32'h0);
    endtask : t_reset
    task automatic t_cfg;
        logic [8:0] v [11] = '{9'h100, 9'h080, 9'h000, 9'h020, 9'h040,
            9'h060, 9'h008, 9'h018, 9'h004, 9'h002, 9'h001};
        for (int i = 0; i < 11; i++)
        begin
            wr_reg(acr_pkg::OFS_CFG_TWO, {23'h7fffff, v[i]});
            #1;
            chk(32'(cfg), 32'(v[i]));
            rd_chk(acr_pkg::OFS_CFG_TWO, 32'(v[i]));
        end
    endtask : t_cfg
    task automatic t_pins;
        wr_reg(acr_pkg::OFS_PIN_LOW, 32'hffffffff);
        #1;
        chk(pins, 32'hfffeffff);
        rd_chk(acr_pkg::OFS_PIN_LOW, 32'hfffeffff);
        wr_reg(acr_pkg::OFS_PIN_LOW, 32'h00010001);
        #1;
        chk(pins, 32'h00000001);
        rd_chk(8'h30, 32'h0);
    endtask : t_pins
    task automatic t_scan;
        int n;
        wr_reg(acr_pkg::OFS_CHAN, 32'h3c);
        #1;
        chk(32'(vref), 32'h1);
        chk(32'(chan), 32'h3c);
        wr_reg(acr_pkg::OFS_CHAN, 32'h3b);
        #1;
        chk(32'(vref), 32'h0);
        chk(32'(chan), 32'h3b);
        wr_reg(acr_pkg::OFS_SCAN, 32'h1);
        #1;
        for (n = 0; n < 8 && start !== 1'b1; n++)
            tick();
        if (n == 8)
        begin
            error_cnt++;
            return;
        end
        tick();
        chk(32'(start), 32'h0);
        rd_chk(acr_pkg::OFS_SCAN, 32'h1);
        @(posedge clk);
        done <= 1'b1;
        cdata <= 12'habc;
        @(posedge clk);
        done <= 1'b0;
        rd_chk(acr_pkg::OFS_RESULT, 32'habc);
        rd_chk(acr_pkg::OFS_SCAN, 32'h0);
        chk(32'(irq), 32'h0);
        rd_chk(acr_pkg::OFS_IRQ_CFG, 32'h2);
        wr_reg(acr_pkg::OFS_RESULT, 32'h0);
        rd_chk(acr_pkg::OFS_RESULT, 32'habc);
        wr_reg(acr_pkg::OFS_IRQ_CFG, 32'h1);
        tick();
        chk(32'(irq), 32'h1);
        rd_chk(acr_pkg::OFS_IRQ_CFG, 32'h3);
        wr_reg(acr_pkg::OFS_IRQ_CFG, 32'h0);
        tick();
        chk(32'(irq), 32'h0);
        wr_reg(acr_pkg::OFS_IRQ_CFG, 32'h4);
        rd_chk(acr_pkg::OFS_IRQ_CFG, 32'h0);
        wr_reg(acr_pkg::OFS_IRQ_MASK, 32'h1);
        tick();
        chk(32'(irq), 32'h1);
        rd_chk(acr_pkg::OFS_IRQ_MASK, 32'h00010001);
        tick();
        chk(32'(irq), 32'h0);
    endtask : t_scan
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_cfg();
        t_pins();
        t_scan();
        give_verdict();
    end
endmodule : acr_regs_tb_top
`default_nettype wire
